// File: hw/mfl_top.sv
// Eight multi-function instances with APB registers and a network scanner.
`timescale 1ns/100ps
`include "mfl_params.svh"
module mfl_top #(
    parameter int NUM_INST = `MFL_NUM_INST,
    parameter int DATA_W = `MFL_DATA_W,
    parameter int LINK_W = `MFL_LINK_W,
    parameter int ADDR_W = `MFL_ADDR_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_tick,
    output logic [LINK_W-1:0] net_rd_addr,
    input wire logic [DATA_W-1:0] net_rd_data,
    output logic [LINK_W-1:0] net_wr_addr,
    output logic [DATA_W-1:0] net_wr_data,
    output logic net_wr_en,
    output logic scan_busy
);
    import mfl_pkg::*;
    localparam int INST_W = (NUM_INST > 1) ? $clog2(NUM_INST) : 1;
    localparam int HI_LSB = `MFL_INST_LSB + INST_W;
    localparam logic [INST_W-1:0] LAST = INST_W'(NUM_INST - 1);
    localparam logic [LINK_W-1:0] DISC = `MFL_LINK_DISC;
    localparam logic [DATA_W-1:0] ONE = DATA_W'(`MFL_LOGIC_ONE);

    typedef struct packed {
        mfl_scan_type state;
        logic [INST_W-1:0] idx;
        logic [DATA_W-1:0] main_val;
        logic [DATA_W-1:0] aux_val;
        logic [LINK_W-1:0] rd_addr;
        logic [LINK_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic wr_en;
        logic [31:0] prdata;
        logic [NUM_INST-1:0][DATA_W-1:0] mon;
    } mfl_top_state_type;

    mfl_top_state_type s_ff;
    mfl_top_state_type nxt_s;

    logic [2:0] mode_a [NUM_INST];
    logic sel_a [NUM_INST];
    logic [LINK_W-1:0] main_a [NUM_INST];
    logic [LINK_W-1:0] aux_a [NUM_INST];
    logic [LINK_W-1:0] tgt_a [NUM_INST];
    logic [NUM_INST-1:0] wr_cfg;
    logic [NUM_INST-1:0] wr_link;
    logic [NUM_INST-1:0] wr_tgt;
    logic [INST_W-1:0] inst;
    logic [3:0] off;
    logic hit;
    logic bad_wr;
    logic acc;
    logic [31:0] rd_val;
    logic [DATA_W-1:0] func_res;
    logic [2:0] cur_mode;
    logic cur_sel;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = ((a >> HI_LSB) == '0) && (a[1:0] == 2'h0) &&
            (int'(a[`MFL_INST_LSB +: INST_W]) < NUM_INST);
    endfunction

    function automatic logic link_ok(input logic [LINK_W-1:0] v);
        link_ok = (v <= `MFL_LINK_MAX);
    endfunction

    assign inst = paddr[`MFL_INST_LSB +: INST_W];
    assign off = paddr[3:0];
    assign hit = addr_hit(paddr);
    assign acc = psel && penable;

    // A write that would set a point outside the network is refused whole.
    always_comb begin
        bad_wr = 1'b0;
        if (pwrite) begin
            case (off)
                `MFL_OFF_LINK: begin
                    bad_wr = !link_ok(pwdata[`MFL_LINK_MAIN_LSB +: LINK_W]) ||
                        !link_ok(pwdata[`MFL_LINK_AUX_LSB +: LINK_W]);
                end
                `MFL_OFF_TGT: begin
                    bad_wr = !link_ok(pwdata[`MFL_TGT_LSB +: LINK_W]);
                end
                `MFL_OFF_MON: bad_wr = 1'b1;
                default: bad_wr = 1'b0;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = acc && (!hit || bad_wr);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INST; gi++) begin : g_inst
            logic sel_me;
            assign sel_me = acc && pwrite && hit && !bad_wr &&
                (inst == INST_W'(gi));
            assign wr_cfg[gi] = sel_me && (off == `MFL_OFF_CFG);
            assign wr_link[gi] = sel_me && (off == `MFL_OFF_LINK);
            assign wr_tgt[gi] = sel_me && (off == `MFL_OFF_TGT);
            mfl_cfg #(
                .LINK_W(LINK_W)
            ) u_cfg (
                .pclk(pclk),
                .presetn(presetn),
                .wr_cfg(wr_cfg[gi]),
                .wr_link(wr_link[gi]),
                .wr_tgt(wr_tgt[gi]),
                .wdata(pwdata),
                .mode(mode_a[gi]),
                .sel(sel_a[gi]),
                .main_link(main_a[gi]),
                .aux_link(aux_a[gi]),
                .tgt_link(tgt_a[gi])
            );
        end
    endgenerate

    always_comb begin
        rd_val = 32'h0000_0000;
        if (hit) begin
            case (off)
                `MFL_OFF_CFG: begin
                    rd_val[`MFL_CFG_MODE_LSB +: 3] = mode_a[inst];
                    rd_val[`MFL_CFG_SEL_BIT] = sel_a[inst];
                end
                `MFL_OFF_LINK: begin
                    rd_val[`MFL_LINK_MAIN_LSB +: LINK_W] = main_a[inst];
                    rd_val[`MFL_LINK_AUX_LSB +: LINK_W] = aux_a[inst];
                end
                `MFL_OFF_TGT: rd_val[`MFL_TGT_LSB +: LINK_W] = tgt_a[inst];
                `MFL_OFF_MON: rd_val[DATA_W-1:0] = s_ff.mon[inst];
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    assign cur_mode = mode_a[s_ff.idx];
    assign cur_sel = sel_a[s_ff.idx];

    mfl_func #(
        .DATA_W(DATA_W)
    ) u_func (
        .mode(cur_mode),
        .sel(cur_sel),
        .main_val(s_ff.main_val),
        .aux_val(s_ff.aux_val),
        .result(func_res)
    );

    // The scan visits the instances in turn, three cycles each. Each output
    // reaches the network before the next tick reads it back, which is what
    // makes a sample-and-hold loop through the network hold steady.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.wr_en = 1'b0;
        if (psel && !penable) begin
            nxt_s.prdata = rd_val;
        end
        case (s_ff.state)
            ST_IDLE: begin
                // A tick that comes while a scan runs is dropped.
                if (sample_tick) begin
                    nxt_s.idx = '0;
                    nxt_s.rd_addr = main_a[0];
                    nxt_s.state = ST_MAIN;
                end
            end
            ST_MAIN: begin
                nxt_s.main_val = net_rd_data;
                nxt_s.rd_addr = aux_a[s_ff.idx];
                nxt_s.state = ST_AUX;
            end
            ST_AUX: begin
                nxt_s.aux_val = net_rd_data;
                nxt_s.state = ST_WRITE;
            end
            ST_WRITE: begin
                nxt_s.wr_data = func_res;
                nxt_s.wr_addr = tgt_a[s_ff.idx];
                nxt_s.wr_en = (tgt_a[s_ff.idx] != DISC);
                nxt_s.mon[s_ff.idx] = func_res;
                if (s_ff.idx == LAST) begin
                    nxt_s.state = ST_IDLE;
                end else begin
                    nxt_s.idx = s_ff.idx + INST_W'(1);
                    nxt_s.rd_addr = main_a[s_ff.idx + INST_W'(1)];
                    nxt_s.state = ST_MAIN;
                end
            end
            default: nxt_s.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.state <= ST_IDLE;
            s_ff.rd_addr <= `MFL_LINK_DISC;
            s_ff.wr_addr <= `MFL_LINK_DISC;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.prdata;
    assign net_rd_addr = s_ff.rd_addr;
    assign net_wr_addr = s_ff.wr_addr;
    assign net_wr_data = s_ff.wr_data;
    assign net_wr_en = s_ff.wr_en;
    assign scan_busy = (s_ff.state != ST_IDLE);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PASS_MAIN: assert property (
        (s_ff.state == ST_WRITE && !cur_sel) |=>
        net_wr_data == $past(s_ff.main_val))
        else $error("Disabled select did not pass the main input.");
    AST_AUX_PASS: assert property (
        (s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h0) |=>
        net_wr_data == $past(s_ff.aux_val))
        else $error("Mode 0 did not pass the auxiliary input.");
    AST_COMPARE: assert property (
        (s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h1) |=>
        net_wr_data == (($signed($past(s_ff.main_val)) >
        $signed($past(s_ff.aux_val))) ? ONE : '0))
        else $error("Comparator result is wrong.");
    AST_AND_GATE: assert property (
        (s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h2 &&
        s_ff.main_val != '0 && s_ff.aux_val != '0) |=> net_wr_data == ONE)
        else $error("Logical AND of two nonzero inputs is not one.");
    AST_INVERT: assert property (
        (s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h4) |=>
        net_wr_data == (($past(s_ff.main_val) == '0) ? ONE : '0))
        else $error("Invert did not invert the main input.");
    AST_NEGATE: assert property (
        (s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h5 &&
        s_ff.main_val[DATA_W-1] == 1'b0) |=>
        net_wr_data == DATA_W'(-$past(s_ff.main_val)))
        else $error("Negate output is not minus the main input.");
    AST_ABS_SIGN: assert property (
        (s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h6) |=>
        net_wr_data[DATA_W-1] == 1'b0)
        else $error("Absolute value came out negative.");
    AST_NO_DISC: assert property (
        net_wr_en |-> net_wr_addr != DISC)
        else $error("Output written to the disconnected point.");
    AST_RANGE: assert property (
        net_rd_addr <= `MFL_LINK_MAX && net_wr_addr <= `MFL_LINK_MAX)
        else $error("Network point outside its range.");
    AST_SCAN_LEN: assert property (
        (s_ff.state == ST_IDLE && sample_tick) |=>
        scan_busy [*8] ##16 (s_ff.state == ST_WRITE) ##1 !scan_busy)
        else $error("Scan did not take the expected number of cycles.");

    COV_SCAN: cover property (s_ff.state == ST_IDLE && sample_tick);
    COV_HOLD: cover property (
        s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h0 &&
        aux_a[s_ff.idx] == tgt_a[s_ff.idx] && tgt_a[s_ff.idx] != DISC);
    COV_CMP_EQ: cover property (
        s_ff.state == ST_WRITE && cur_sel && cur_mode == 3'h1 &&
        s_ff.main_val == s_ff.aux_val);
    COV_ERR: cover property (pslverr);
endmodule

// File: hw/mfl_params.svh
// Constants of the multi-function logic block: offsets, fields, resets.
`ifndef MFL_PARAMS_SVH
`define MFL_PARAMS_SVH
`define MFL_NUM_INST 8
`define MFL_DATA_W 16
`define MFL_LINK_W 10
`define MFL_ADDR_W 12
`define MFL_LINK_MAX 10'h2D0
`define MFL_LINK_DISC 10'h190
`define MFL_MODE_RST 3'h0
`define MFL_SEL_RST 1'b0
`define MFL_LOGIC_ONE 16'h0001
`define MFL_OFF_CFG 4'h0
`define MFL_OFF_LINK 4'h4
`define MFL_OFF_TGT 4'h8
`define MFL_OFF_MON 4'hC
`define MFL_INST_LSB 4
`define MFL_CFG_MODE_LSB 0
`define MFL_CFG_SEL_BIT 4
`define MFL_LINK_MAIN_LSB 0
`define MFL_LINK_AUX_LSB 16
`define MFL_TGT_LSB 0
`define MFL_SCAN_CYCLES 24
`endif

// File: hw/mfl_pkg.sv
// Types shared by the multi-function logic block.
package mfl_pkg;
    typedef enum logic [2:0] {
        MFL_AUX = 3'h0,
        MFL_CMP = 3'h1,
        MFL_AND = 3'h2,
        MFL_OR = 3'h3,
        MFL_INV = 3'h4,
        MFL_NEG = 3'h5,
        MFL_ABS = 3'h6
    } mfl_mode_type;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MAIN,
        ST_AUX,
        ST_WRITE
    } mfl_scan_type;
endpackage

// File: hw/mfl_func.sv
// Transfer function of one multi-function instance, purely combinational.
`timescale 1ns/100ps
`include "mfl_params.svh"
module mfl_func #(
    parameter int DATA_W = `MFL_DATA_W
) (
    input wire logic [2:0] mode,
    input wire logic sel,
    input wire logic [DATA_W-1:0] main_val,
    input wire logic [DATA_W-1:0] aux_val,
    output logic [DATA_W-1:0] result
);
    import mfl_pkg::*;
    localparam logic [DATA_W-1:0] ONE = DATA_W'(`MFL_LOGIC_ONE);
    localparam logic [DATA_W-1:0] MOST_NEG = {1'b1, {(DATA_W-1){1'b0}}};
    localparam logic [DATA_W-1:0] MOST_POS = {1'b0, {(DATA_W-1){1'b1}}};

    function automatic logic truth(input logic [DATA_W-1:0] v);
        truth = (v != '0);
    endfunction

    logic [DATA_W-1:0] neg;

    always_comb begin
        // The most negative value has no positive twin, so it saturates.
        neg = (main_val == MOST_NEG) ? MOST_POS : DATA_W'(-main_val);
        if (!sel) begin
            result = main_val;
        end else begin
            case (mode)
                MFL_AUX: result = aux_val;
                MFL_CMP: begin
                    // Equal inputs give 0: only strictly greater is true.
                    result = ($signed(main_val) > $signed(aux_val)) ?
                        ONE : '0;
                end
                MFL_AND: begin
                    result = (truth(main_val) && truth(aux_val)) ?
                        ONE : '0;
                end
                MFL_OR: begin
                    result = (truth(main_val) || truth(aux_val)) ?
                        ONE : '0;
                end
                MFL_INV: result = truth(main_val) ? '0 : ONE;
                MFL_NEG: result = neg;
                MFL_ABS: result = main_val[DATA_W-1] ? neg : main_val;
                default: result = main_val;
            endcase
        end
    end
endmodule

// File: hw/mfl_cfg.sv
// Configuration registers of one multi-function instance.
`timescale 1ns/100ps
`include "mfl_params.svh"
module mfl_cfg #(
    parameter int LINK_W = `MFL_LINK_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_cfg,
    input wire logic wr_link,
    input wire logic wr_tgt,
    input wire logic [31:0] wdata,
    output logic [2:0] mode,
    output logic sel,
    output logic [LINK_W-1:0] main_link,
    output logic [LINK_W-1:0] aux_link,
    output logic [LINK_W-1:0] tgt_link
);
    import mfl_pkg::*;
    typedef struct packed {
        logic [2:0] mode;
        logic sel;
        logic [LINK_W-1:0] main_link;
        logic [LINK_W-1:0] aux_link;
        logic [LINK_W-1:0] tgt_link;
    } mfl_cfg_state_type;

    mfl_cfg_state_type s_ff;
    mfl_cfg_state_type nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (wr_cfg) begin
            nxt_s.mode = wdata[`MFL_CFG_MODE_LSB +: 3];
            nxt_s.sel = wdata[`MFL_CFG_SEL_BIT];
        end
        if (wr_link) begin
            nxt_s.main_link = wdata[`MFL_LINK_MAIN_LSB +: LINK_W];
            nxt_s.aux_link = wdata[`MFL_LINK_AUX_LSB +: LINK_W];
        end
        if (wr_tgt) begin
            nxt_s.tgt_link = wdata[`MFL_TGT_LSB +: LINK_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff.mode <= `MFL_MODE_RST;
            s_ff.sel <= `MFL_SEL_RST;
            s_ff.main_link <= `MFL_LINK_DISC;
            s_ff.aux_link <= `MFL_LINK_DISC;
            s_ff.tgt_link <= `MFL_LINK_DISC;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mode = s_ff.mode;
    assign sel = s_ff.sel;
    assign main_link = s_ff.main_link;
    assign aux_link = s_ff.aux_link;
    assign tgt_link = s_ff.tgt_link;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_MODE_WRITE: assert property (
        wr_cfg |=> mode == $past(wdata[`MFL_CFG_MODE_LSB +: 3]))
        else $error("Mode setting did not take the written code.");
    AST_LINK_HOLD: assert property (
        !wr_link |=> $stable(main_link) && $stable(aux_link))
        else $error("Source link changed without a write.");
endmodule

// File: dv/mfl_net_model.sv
// Signal network model: point memory read combinationally, written on strobe.
`timescale 1ns/100ps
`include "mfl_params.svh"
module mfl_net_model (
    input wire logic pclk,
    input wire logic [9:0] net_rd_addr,
    output logic [15:0] net_rd_data,
    input wire logic [9:0] net_wr_addr,
    input wire logic [15:0] net_wr_data,
    input wire logic net_wr_en
);
    logic [15:0] mem [0:720];
    integer k;
    initial begin
        for (k = 0; k <= 720; k++) begin
            mem[k] = 16'h0000;
        end
    end
    // The disconnected point reads as zero so a dangling input acts as 0.
    always_comb begin
        if (net_rd_addr == `MFL_LINK_DISC) begin
            net_rd_data = 16'h0000;
        end else begin
            net_rd_data = mem[net_rd_addr];
        end
    end
    always @(posedge pclk) begin
        if (net_wr_en === 1'b1 && net_wr_addr != `MFL_LINK_DISC) begin
            mem[net_wr_addr] <= net_wr_data;
        end
    end
endmodule

// File: dv/mfl_top_tb.sv
// Self-checking bench for the function block against a network model.
`timescale 1ns/100ps
`include "mfl_params.svh"
module mfl_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sample_tick, net_wr_en, scan_busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] net_rd_addr, net_wr_addr;
    logic [15:0] net_rd_data, net_wr_data, mv, av, last;
    logic [2:0] md;
    logic sl;
    integer num_errors = 0, n_tests = 0, seed = 25, t, i;
    logic [33:0] q_apb[$];
    logic [25:0] q_net[$];

    mfl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_tick(sample_tick),
        .net_rd_addr(net_rd_addr), .net_rd_data(net_rd_data),
        .net_wr_addr(net_wr_addr), .net_wr_data(net_wr_data),
        .net_wr_en(net_wr_en), .scan_busy(scan_busy));
    mfl_net_model net_u (.pclk(pclk), .net_rd_addr(net_rd_addr),
        .net_rd_data(net_rd_data), .net_wr_addr(net_wr_addr),
        .net_wr_data(net_wr_data), .net_wr_en(net_wr_en));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task check(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task finish_test();
        $display("Comparisons %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Expected entry: bit 33 compare data, bit 32 error, then read data.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [33:0] e);
        @(posedge pclk);
        q_apb.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, {1'b0, err, 32'h0});
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x, input logic err);
        apb(1'b0, a, 32'h0, {1'b1, err, x});
    endtask

    // Extra edges after busy drops let the last write reach the monitor.
    task tick();
        integer k;
        @(posedge pclk);
        sample_tick <= 1'b1;
        @(posedge pclk);
        sample_tick <= 1'b0;
        @(posedge pclk);
        for (k = 0; k < 40 && scan_busy === 1'b1; k++) @(posedge pclk);
        check(34'(k), 34'(`MFL_SCAN_CYCLES));
        repeat (2) @(posedge pclk);
        check(34'(q_net.size()), 34'h0);
    endtask

    task hold_step(input logic [31:0] cfg, input logic [15:0] m,
                   input logic [15:0] x);
        net_u.mem[10] = m;
        wr(12'h000, cfg, 1'b0);
        q_net.push_back({10'd100, x});
        tick();
    endtask

    function automatic logic [15:0] f_exp(logic [2:0] m, logic s,
                                          logic [15:0] a, logic [15:0] b);
        logic [15:0] r;
        logic [15:0] neg;
        neg = (a == 16'h8000) ? 16'h7FFF : -a;
        r = a;
        if (s) begin
            case (m)
                3'h0: r = b;
                3'h1: r = 16'($signed(a) > $signed(b));
                3'h2: r = 16'(a != 16'h0 && b != 16'h0);
                3'h3: r = 16'(a != 16'h0 || b != 16'h0);
                3'h4: r = 16'(a == 16'h0);
                3'h5: r = neg;
                default: r = a[15] ? neg : a;
            endcase
        end
        return r;
    endfunction

    function automatic logic [15:0] rnd_val();
        integer c;
        c = $unsigned($random(seed)) % 4;
        return (c == 0) ? 16'h0 : (c == 1) ? 16'h8000 : 16'($random(seed));
    endfunction

    always @(posedge pclk) begin : apb_mon
        logic [33:0] e;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = q_apb.pop_front();
            check({33'h0, pslverr}, {33'h0, e[32]});
            if (e[33]) check({2'b0, prdata}, {2'b0, e[31:0]});
        end
    end

    always @(posedge pclk) begin
        if (net_wr_en === 1'b1) begin
            if (q_net.size() == 0)
                check({8'h0, net_wr_addr, net_wr_data}, {34{1'b1}});
            else
                check({8'h0, net_wr_addr, net_wr_data},
                      {8'h0, q_net.pop_front()});
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        finish_test();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sample_tick = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(12'(i * 16), 32'h0, 1'b0);
            rd(12'(i * 16 + 4), 32'h01900190, 1'b0);
            rd(12'(i * 16 + 8), 32'h190, 1'b0);
        end
        tick();
        rd(12'h080, 32'h0, 1'b1);
        rd(12'h006, 32'h0, 1'b1);
        wr(12'h00C, 32'h1, 1'b1);
        wr(12'h004, 32'h000002D1, 1'b1);
        wr(12'h004, 32'h02D10000, 1'b1);
        wr(12'h008, 32'h000002D1, 1'b1);
        rd(12'h004, 32'h01900190, 1'b0);
        rd(12'h008, 32'h190, 1'b0);
        wr(12'h004, 32'h02D002D0, 1'b0);
        rd(12'h004, 32'h02D002D0, 1'b0);
        for (i = 0; i < 8; i++) begin
            wr(12'(i * 16 + 4), {16'(20 + i), 16'(10 + i)}, 1'b0);
            wr(12'(i * 16 + 8), 32'(100 + i), 1'b0);
        end
        // Every mode meets every instance; zeros, equals and 0x8000 recur.
        for (t = 0; t < 24; t++) begin
            for (i = 0; i < 8; i++) begin
                md = 3'((t + i) % 7);
                sl = 1'($random(seed));
                mv = rnd_val();
                av = ($unsigned($random(seed)) % 3 == 0) ? mv : rnd_val();
                net_u.mem[10 + i] = mv;
                net_u.mem[20 + i] = av;
                wr(12'(i * 16), {27'h0, sl, 1'b0, md}, 1'b0);
                last = f_exp(md, sl, mv, av);
                q_net.push_back({10'(100 + i), last});
            end
            tick();
        end
        rd(12'h07C, {16'h0, last}, 1'b0);
        for (i = 1; i < 8; i++) wr(12'(i * 16 + 8), 32'h190, 1'b0);
        wr(12'h004, {16'd100, 16'd10}, 1'b0);
        hold_step(32'h00, 16'h1234, 16'h1234);
        hold_step(32'h10, 16'h4321, 16'h1234);
        hold_step(32'h10, 16'h5555, 16'h1234);
        hold_step(32'h00, 16'h4321, 16'h4321);
        // Code 7 is no function of its own; it must fall back to main.
        hold_step(32'h17, 16'h2468, 16'h2468);
        finish_test();
    end
endmodule
